// File: src/burst_cache_tag.v
// tag and data ram slice with burst counter, comparator, parity and open-drain match outputs
`timescale 1ns/1ps
`include "burst_cache_tag_map.vh"

module burst_cache_tag (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 rst,
  // processor burst handshake
  input  wire                 burst_req_n,
  input  wire                 burst_ack_n,
  input  wire                 sync_term_n,
  // access control
  input  wire                 addr_strobe_n,
  input  wire                 write_en_n,
  input  wire                 select_n,
  input  wire                 force_match_high_in,
  input  wire                 top_bit_compare_enable,
  // address and tag/data in
  input  wire [`ADDR_W-1:0]   addr_in,
  input  wire [`DATA_W-1:0]   data_in,
  // stored word, parity flag and burst state out
  output reg  [`DATA_W-1:0]   data_out,
  output reg                  parity_error,
  output reg                  burst_active,
  // open-drain match pins
  output reg                  match_buserr_out,
  output reg                  match_buserr_oe_n,
  output reg                  match_halt_out,
  output reg                  match_halt_oe_n
);

  // every pin except core_clk and rst is asynchronous to core_clk, so all of those pass two flops
  wire [`SYNC_W-1:0] pins_raw;
  reg  [`SYNC_W-1:0] sync1_reg;
  reg  [`SYNC_W-1:0] sync2_reg;

  assign pins_raw = {burst_req_n, burst_ack_n, sync_term_n, addr_strobe_n,
                     write_en_n, select_n, force_match_high_in,
                     top_bit_compare_enable, addr_in, data_in};

  // first stage may go metastable; only the second stage is read below
  always @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= `SYNC_RST;
    end else begin
      sync1_reg <= pins_raw;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      sync2_reg <= `SYNC_RST;
    end else begin
      sync2_reg <= sync1_reg;
    end
  end

  // synchronised copies, the only versions of the pins that logic reads
  wire               req_n    = sync2_reg[`S_REQ_N];
  wire               ack_n    = sync2_reg[`S_ACK_N];
  wire               term_n   = sync2_reg[`S_TERM_N];
  wire               strobe_n = sync2_reg[`S_STROBE_N];
  wire               wr_n     = sync2_reg[`S_WRITE_N];
  wire               sel_n    = sync2_reg[`S_SELECT_N];
  wire               force_hi = sync2_reg[`S_FORCE];
  wire               comp_top = sync2_reg[`S_COMP_TOP];
  wire [`ADDR_W-1:0] addr     = sync2_reg[`S_ADDR_HI:`S_ADDR_LO];
  wire [`DATA_W-1:0] din      = sync2_reg[`S_DATA_HI:`S_DATA_LO];

  // burst select register and word counter
  reg                 burst_select_register;
  reg                 burst_select_next;
  reg [`BURST_W-1:0]  count_reg;
  reg [`BURST_W-1:0]  count_next;

  // burst handshake decode on the synchronised pins
  wire                burst_clear;
  wire                burst_edge;
  wire                burst_load;
  wire                burst_step;
  wire [`BURST_W-1:0] word_addr;

  // one clock only: the clear acts at the next edge, not asynchronously
  assign burst_clear = req_n || ack_n;
  assign burst_edge  = !burst_clear && !term_n;
  // first counting edge of a burst loads, later ones advance
  assign burst_load  = burst_edge && !burst_select_register;
  assign burst_step  = burst_edge && burst_select_register;
  assign word_addr   = addr[`BURST_W-1:0];

  always @* begin
    burst_select_next = burst_select_register;
    if (burst_clear) begin
      burst_select_next = `BURST_SEL_RST;
    end else if (burst_edge) begin
      burst_select_next = 1'b1;
    end
  end

  // counter width alone gives the wrap over the aligned four-word block
  always @* begin
    count_next = count_reg;
    if (burst_load) begin
      count_next = word_addr + `COUNT_STEP;
    end else if (burst_step) begin
      count_next = count_reg + `COUNT_STEP;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      burst_select_register <= `BURST_SEL_RST;
    end else begin
      burst_select_register <= burst_select_next;
    end
  end

  // a refill word is written on the same edge that advances the count
  always @(posedge core_clk) begin
    if (rst) begin
      count_reg <= `COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // ram index: upper index bits from the bus, low two from bus or counter
  wire [`INDEX_HI_W-1:0] block_addr;
  wire [`BURST_W-1:0]    low_index;
  wire [`ADDR_W-1:0]     ram_index;

  assign block_addr = addr[`ADDR_W-1:`BURST_W];
  assign low_index  = burst_select_register ? count_reg : word_addr;
  assign ram_index  = {block_addr, low_index};

  // storage: nine bits per entry, ninth bit is parity
  reg  [`WORD_W-1:0] ram_mem [0:`DEPTH-1];
  wire [`WORD_W-1:0] stored;
  wire [`DATA_W-1:0] stored_data;
  wire               stored_parity;
  wire [`WORD_W-1:0] write_word;
  wire               write_parity;
  wire               write_now;

  // contents are not reset; the controller must write an entry before use
  assign stored        = ram_mem[ram_index];
  assign stored_data   = stored[`DATA_W-1:0];
  assign stored_parity = stored[`PARITY_BIT];
  // even parity: the nine stored bits always xor to zero
  assign write_parity  = ^din;
  assign write_word    = {write_parity, din};
  assign write_now     = !wr_n && !strobe_n && !sel_n;

  always @(posedge core_clk) begin
    if (write_now) begin
      ram_mem[ram_index] <= write_word;
    end
  end

  // per-bit tag compare; top bit can be masked to serve as a dirty flag
  wire [`DATA_W-1:0] compare_mask;
  wire [`DATA_W-1:0] bit_miss;
  genvar gi;
  generate
    for (gi = 0; gi < `DATA_W; gi = gi + 1) begin : g_cmp
      if (gi == `TOP_TAG_BIT) begin : g_top
        assign compare_mask[gi] = comp_top;
      end else begin : g_low
        assign compare_mask[gi] = 1'b1;
      end
      assign bit_miss[gi] = compare_mask[gi] & (stored_data[gi] ^ din[gi]);
    end
  endgenerate

  // access qualifiers and compare results
  wire               hit;
  wire               reading;
  wire               parity_bad;
  wire               first_word;
  wire               miss;

  assign hit        = ~|bit_miss;
  assign reading    = !strobe_n && wr_n && !sel_n;
  assign parity_bad = stored_parity ^ (^stored_data);
  // halt decision uses the burst select state from before this edge
  assign first_word = !burst_select_register;
  // a miss is only signalled on a live read of a selected, unforced part
  assign miss       = reading && !hit && !force_hi;

  // next values of the registered outputs
  reg [`DATA_W-1:0]  data_out_next;
  reg                parity_error_next;
  reg                burst_active_next;
  reg                match_buserr_oe_n_next;
  reg                match_halt_oe_n_next;

  always @* begin
    data_out_next          = stored_data;
    parity_error_next      = 1'b0;
    burst_active_next      = burst_select_next;
    match_buserr_oe_n_next = `OE_N_RST;
    match_halt_oe_n_next   = `OE_N_RST;
    if (reading) begin
      parity_error_next = parity_bad;
    end
    if (miss) begin
      match_buserr_oe_n_next = 1'b0;
      if (first_word) begin
        match_halt_oe_n_next = 1'b0;
      end else begin
        // later burst words end the burst without asking for a rerun
        match_halt_oe_n_next = `OE_N_RST;
      end
    end
  end

  // stored word, refreshed every edge
  always @(posedge core_clk) begin
    if (rst) begin
      data_out <= `DATA_OUT_RST;
    end else begin
      data_out <= data_out_next;
    end
  end

  // parity flag stands for the cycle that read the bad word
  always @(posedge core_clk) begin
    if (rst) begin
      parity_error <= 1'b0;
    end else begin
      parity_error <= parity_error_next;
    end
  end

  // lets the outside see the burst select state
  always @(posedge core_clk) begin
    if (rst) begin
      burst_active <= `BURST_SEL_RST;
    end else begin
      burst_active <= burst_active_next;
    end
  end

  // open-drain enables: low only while pulling the shared line low
  always @(posedge core_clk) begin
    if (rst) begin
      match_buserr_oe_n <= `OE_N_RST;
    end else begin
      match_buserr_oe_n <= match_buserr_oe_n_next;
    end
  end

  // halt is let go again once the burst is past its first word
  always @(posedge core_clk) begin
    if (rst) begin
      match_halt_oe_n <= `OE_N_RST;
    end else begin
      match_halt_oe_n <= match_halt_oe_n_next;
    end
  end

  // open drain: data lines fixed low, only the enables move
  always @(posedge core_clk) begin
    if (rst) begin
      match_buserr_out <= 1'b0;
    end else begin
      match_buserr_out <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      match_halt_out <= 1'b0;
    end else begin
      match_halt_out <= 1'b0;
    end
  end

endmodule

// File: src/burst_cache_tag_map.vh
// constants for the burst cache tag comparator slice
`ifndef BURST_CACHE_TAG_MAP_VH
`define BURST_CACHE_TAG_MAP_VH

// array geometry
`define ADDR_W          11
`define DATA_W          8
`define WORD_W          9
`define DEPTH           2048
`define BURST_W         2
`define INDEX_HI_W      9

// field positions inside a stored word
`define PARITY_BIT      8
`define TOP_TAG_BIT     7

// pin bundle passed through the input synchroniser
`define SYNC_W          27
`define S_REQ_N         26
`define S_ACK_N         25
`define S_TERM_N        24
`define S_STROBE_N      23
`define S_WRITE_N       22
`define S_SELECT_N      21
`define S_FORCE         20
`define S_COMP_TOP      19
`define S_ADDR_HI       18
`define S_ADDR_LO       8
`define S_DATA_HI       7
`define S_DATA_LO       0

// reset values
`define SYNC_RST        27'h7E80000
`define BURST_SEL_RST   1'b0
`define COUNT_RST       2'h0
`define COUNT_STEP      2'h1
`define DATA_OUT_RST    8'h00
`define OE_N_RST        1'b1

`endif

// File: verif/burst_cache_tag_asserts.sv
// concurrent checks on the burst cache tag slice ports
`timescale 1ns/1ps
module burst_cache_tag_asserts (
  // clock, reset and pins
  input wire logic core_clk, rst, burst_req_n, burst_ack_n, sync_term_n,
  input wire logic addr_strobe_n, write_en_n, select_n, force_match_high_in,
  // outputs watched
  input wire logic burst_active, match_buserr_out, match_buserr_oe_n,
  input wire logic match_halt_out, match_halt_oe_n
);
  logic [1:0] run_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // synchronisers hold inactive pins for three edges after reset
  always @(posedge core_clk) run_reg <= rst ? 2'h0 : (run_reg == 2'h3 ? 2'h3 : run_reg + 2'h1);
  a_force_release: assert property ($past(force_match_high_in, 3) |-> match_buserr_oe_n && match_halt_oe_n) else $error("force ignored");
  a_deselect_release: assert property ($past(select_n, 3) |-> match_buserr_oe_n && match_halt_oe_n) else $error("deselected miss");
  a_idle_release: assert property ($past(addr_strobe_n, 3) || !$past(write_en_n, 3) |-> match_buserr_oe_n) else $error("idle miss");
  a_halt_needs_berr: assert property (!match_halt_oe_n |-> !match_buserr_oe_n) else $error("halt alone");
  a_open_drain: assert property (match_buserr_out == 1'h0 && match_halt_out == 1'h0) else $error("drives high");
  a_burst_clear: assert property ($past(burst_req_n, 3) || $past(burst_ack_n, 3) |-> !burst_active) else $error("burst kept");
  a_burst_set: assert property (run_reg == 2'h3 && !$past(burst_req_n, 3) && !$past(burst_ack_n, 3) && !$past(sync_term_n, 3) |-> burst_active) else $error("burst not set");
  a_burst_halt_held: assert property ($past(burst_active) |-> match_halt_oe_n) else $error("halt in burst");
endmodule
bind burst_cache_tag burst_cache_tag_asserts chk_i (.core_clk, .rst, .burst_req_n, .burst_ack_n,
  .sync_term_n, .addr_strobe_n, .write_en_n, .select_n, .force_match_high_in, .burst_active,
  .match_buserr_out, .match_buserr_oe_n, .match_halt_out, .match_halt_oe_n);

// File: verif/burst_cache_tag_bench.sv
// self-checking bench for the burst cache tag slice
`timescale 1ns/1ps
module burst_cache_tag_bench;
  logic core_clk = 0, rst = 1, burst_req_n = 1, burst_ack_n = 1, sync_term_n = 1;
  logic addr_strobe_n = 0, write_en_n = 1, select_n = 0, force_match_high_in = 0;
  logic top_bit_compare_enable = 1, parity_error, burst_active, match_buserr_out;
  logic match_buserr_oe_n, match_halt_out, match_halt_oe_n, berr_n, halt_n, sb, sh, sa;
  logic [10:0] addr_in = 0, base;
  logic [7:0] data_in = 0, tag, data_out;
  int error_cnt = 0, cmp_count = 0;
  always #5 core_clk = ~core_clk;
  burst_cache_tag uut (.core_clk, .rst, .burst_req_n, .burst_ack_n, .sync_term_n, .addr_strobe_n,
    .write_en_n, .select_n, .force_match_high_in, .top_bit_compare_enable, .addr_in, .data_in,
    .data_out, .parity_error, .burst_active, .match_buserr_out, .match_buserr_oe_n,
    .match_halt_out, .match_halt_oe_n);
  cpu_bus_model bus (.match_buserr_out, .match_buserr_oe_n, .match_halt_out, .match_halt_oe_n,
    .berr_n, .halt_n);
  function logic [1:0] lines(input logic [7:0] st, cmp, input logic top);
    return (top ? st == cmp : st[6:0] == cmp[6:0]) ? 2'h3 : 2'h0;
  endfunction
  task chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task put(input logic [10:0] a, input logic [7:0] d);
    addr_in = a;
    data_in = d;
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #3000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h560E));
    repeat (10) @(posedge core_clk);
    #1 rst = 0;
    base = $urandom;
    base[1:0] = 2'h0;
    tag = $urandom;
    write_en_n = 0;
    // word zero of the block gets a foreign tag
    for (int i = 0; i < 4; i++) put(base + i, i ? tag : ~tag);
    write_en_n = 1;
    put(base + 1, tag);
    chk({berr_n, halt_n}, lines(tag, tag, 1));
    chk(data_out, tag);
    chk(parity_error, 0);
    put(base, tag);
    chk({berr_n, halt_n}, lines(~tag, tag, 1));
    force_match_high_in = 1;
    put(base, tag);
    chk({berr_n, halt_n}, 2'h3);
    {force_match_high_in, select_n} = 2'h1;
    put(base, tag);
    chk({berr_n, halt_n}, 2'h3);
    {select_n, top_bit_compare_enable} = 2'h0;
    put(base + 1, tag ^ 8'h80);
    chk({berr_n, halt_n}, lines(tag, tag ^ 8'h80, 0));
    top_bit_compare_enable = 1;
    put(base + 1, tag ^ 8'h80);
    chk({berr_n, halt_n}, lines(tag, tag ^ 8'h80, 1));
    $display("test single access done");
    put(base + 1, tag);
    {burst_req_n, burst_ack_n, sync_term_n, sb, sh, sa} = 6'h0;
    repeat (8) begin
      @(posedge core_clk);
      #1 {sb, sh, sa} = {sb | !berr_n, sh | !halt_n, sa | burst_active};
    end
    chk(sb, 1);
    chk(sh, 0);
    chk(sa, 1);
    {burst_req_n, burst_ack_n, sync_term_n} = 3'h7;
    put(base + 1, tag);
    chk(burst_active, 0);
    $display("test burst done");
    report_and_stop;
  end
endmodule

// File: verif/cpu_bus_model.sv
// processor side match nets with pull-ups
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire logic match_buserr_out, match_buserr_oe_n, match_halt_out, match_halt_oe_n,
  output wire logic berr_n, halt_n
);
  // released nets rise to the pull-up level
  assign berr_n = match_buserr_oe_n ? 1'h1 : match_buserr_out;
  assign halt_n = match_halt_oe_n ? 1'h1 : match_halt_out;
endmodule
